// File: rtl/dmi_top.sv
// data memory with pointer based indirect access and working register
//
// the core is the only client. it raises rd_en_in or wr_en_in for one cycle
// per access, and the request is taken on that rising edge. read data and
// rvalid_out stand for exactly one cycle after the edge that took the read.
// writes to special locations are visible on the outputs one cycle later.
//
// addresses 00h and 02h are the indirect ports. they hold nothing; any access
// to them is steered to the address in the paired pointer. an access whose
// pointer names a port again reads zero and writes nothing.
//
// the special area holds the two pointers, the working register and one
// protected status byte that only hardware may update. every other special
// location reads zero and drops writes.
//
// ram bit operations are read, merge and write: the byte is read on the edge
// that takes the request and the merged byte is written on the next edge.
// the core must leave that next cycle free of ram writes; a byte written
// then would be lost under the merged one. a read of the same byte in that
// cycle returns the byte before the merge. this keeps the ram single ported
// at the cost of one idle cycle after each ram bit operation.
//
// bank_in is kept for a map with more than one bank; with one bank it is
// not decoded and pointer zero is masked to the single bank.
`timescale 1ns/100ps
`include "dmi_consts.svh"
module dmi_top
    import dmi_pkg::*;
#(
    parameter int BANK_BITS = 0
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic rd_en_in,
    input wire logic wr_en_in,
    input wire logic [7:0] addr_in,
    input wire dmi_op_t op_in,
    input wire logic [2:0] bit_sel_in,
    input wire logic [7:0] wdata_in,
    input wire logic [BANK_BITS:0] bank_in,
    input wire logic alu_we_in,
    input wire logic [7:0] alu_result_in,
    input wire logic prot_we_in,
    input wire logic [7:0] prot_data_in,
    output logic [7:0] rdata_out,
    output logic rvalid_out,
    output logic [7:0] working_register_out,
    output logic [7:0] pointer_zero_out,
    output logic [7:0] pointer_one_out,
    output logic [7:0] protected_out
);
    // all block state in one record
    typedef struct packed {
        logic [7:0] ptr0;
        logic [7:0] ptr1;
        logic [7:0] wreg;
        logic [7:0] prot;
        logic rd_gpr;
        logic rvalid;
        logic [7:0] sfr_rdata;
        logic pend;
        logic [7:0] pend_addr;
        dmi_op_t pend_op;
        logic [2:0] pend_bit;
    } dmi_state_t;

    dmi_state_t st_r;
    dmi_state_t st_nxt;
    dmi_ram_if ram_bus ();
    logic [7:0] eff_addr;
    logic is_gpr;
    logic is_ind;
    logic [7:0] merged;

    // resolve indirect ports through their pointer (current value, so a write
    // in the previous access is already seen)
    function automatic logic [7:0] dmi_resolve(input logic [7:0] a, input logic [7:0] p0, input logic [7:0] p1);
        if (a == `DMI_ADDR_IND0)
            dmi_resolve = p0 & `DMI_BANK0_MASK;
        else if (a == `DMI_ADDR_IND1)
            dmi_resolve = p1;
        else
            dmi_resolve = a;
    endfunction

    // bit operation on a byte
    function automatic logic [7:0] dmi_bitop(input dmi_op_t op, input logic [7:0] old, input logic [2:0] b,
                                             input logic [7:0] wd);
        logic [7:0] m;
        m = 8'h01 << b;
        case (op)
            DMI_OP_BSET: dmi_bitop = old | m;
            DMI_OP_BCLR: dmi_bitop = old & ~m;
            default: dmi_bitop = wd;
        endcase
    endfunction

    // bank input only matters once the map grows past one bank
    assign eff_addr = dmi_resolve(addr_in, st_r.ptr0, st_r.ptr1);
    assign is_gpr = eff_addr >= `DMI_GPR_FIRST;
    assign is_ind = (eff_addr == `DMI_ADDR_IND0) || (eff_addr == `DMI_ADDR_IND1);

    // special registers merge bit operations in place; ram bit operations
    // are queued in the pend fields and merged on the next edge
    always_comb
    begin
        logic [7:0] sfr_old;
        sfr_old = `DMI_ZERO_BYTE;
        case (eff_addr)
            `DMI_ADDR_PTR0: sfr_old = st_r.ptr0;
            `DMI_ADDR_PTR1: sfr_old = st_r.ptr1;
            `DMI_ADDR_WREG: sfr_old = st_r.wreg;
            `DMI_ADDR_PROT: sfr_old = st_r.prot;
            default: sfr_old = `DMI_ZERO_BYTE;
        endcase
        merged = dmi_bitop(op_in, sfr_old, bit_sel_in, wdata_in);
        st_nxt = st_r;
        st_nxt.rvalid = rd_en_in;
        st_nxt.rd_gpr = rd_en_in && is_gpr;
        st_nxt.sfr_rdata = rd_en_in ? sfr_old : `DMI_ZERO_BYTE;
        // ram bit operation: the old byte is read now, merged next cycle
        st_nxt.pend = wr_en_in && is_gpr && (op_in != DMI_OP_BYTE);
        st_nxt.pend_addr = eff_addr;
        st_nxt.pend_op = op_in;
        st_nxt.pend_bit = bit_sel_in;
        if (wr_en_in && !is_gpr && !is_ind)
        begin
            case (eff_addr)
                `DMI_ADDR_PTR0: st_nxt.ptr0 = merged;
                `DMI_ADDR_PTR1: st_nxt.ptr1 = merged;
                `DMI_ADDR_WREG: st_nxt.wreg = merged;
                default: ; // unused and protected: dropped
            endcase
        end
        if (alu_we_in)
        begin
            st_nxt.wreg = alu_result_in; // alu wins over a bus write
        end
        if (prot_we_in)
        begin
            st_nxt.prot = prot_data_in; // only hardware updates it
        end
        if (!rst_n_in)
        begin
            st_nxt.ptr0 = `DMI_RST_BYTE;
            st_nxt.ptr1 = `DMI_RST_BYTE;
            st_nxt.wreg = `DMI_RST_BYTE;
            st_nxt.prot = `DMI_RST_BYTE;
            st_nxt.rd_gpr = 1'b0;
            st_nxt.rvalid = 1'b0;
            st_nxt.sfr_rdata = `DMI_ZERO_BYTE;
            st_nxt.pend = 1'b0;
            st_nxt.pend_addr = `DMI_ZERO_BYTE;
            st_nxt.pend_op = DMI_OP_BYTE;
            st_nxt.pend_bit = 3'h0;
        end
    end

    // state register
    always_ff @(posedge clk_in)
    begin
        st_r <= st_nxt;
    end

    // ram port, eight bits per location a pending bit operation
    // owns the write port for its one cycle, so a bus write then is lost
    assign ram_bus.we = st_r.pend || (wr_en_in && is_gpr && (op_in == DMI_OP_BYTE));
    assign ram_bus.waddr = st_r.pend ? st_r.pend_addr : eff_addr;
    // read data of the queued address is standing now, merge it
    assign ram_bus.wdata = st_r.pend ? dmi_bitop(st_r.pend_op, ram_bus.rdata, st_r.pend_bit, ram_bus.rdata)
                                     : wdata_in;
    assign ram_bus.raddr = eff_addr;

    dmi_ram #(
        .DEPTH(256)
    ) u_ram (
        .clk_in(clk_in),
        .bus(ram_bus)
    );

    // outputs
    assign rdata_out = st_r.rd_gpr ? ram_bus.rdata : st_r.sfr_rdata;
    assign rvalid_out = st_r.rvalid;
    assign working_register_out = st_r.wreg;
    assign pointer_zero_out = st_r.ptr0;
    assign pointer_one_out = st_r.ptr1;
    assign protected_out = st_r.prot;

    // a port that resolves to a port again has nothing behind it
    a_ind_read_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rd_en_in && is_ind |=> rdata_out == 8'h00)
        else $error("indirect self read not zero");
    // the hole at 04h in the special area reads back as zero
    a_unused_read_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rd_en_in && eff_addr == `DMI_ADDR_UNUSED |=> rdata_out == 8'h00)
        else $error("unused read not zero");
    // pointer zero takes a byte write on the next edge
    a_ptr0_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_en_in && op_in == DMI_OP_BYTE && eff_addr == `DMI_ADDR_PTR0 |=> pointer_zero_out == $past(wdata_in))
        else $error("pointer zero write lost");
    // port one goes through pointer one
    a_ind_redirect: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        addr_in == `DMI_ADDR_IND1 |-> eff_addr == pointer_one_out)
        else $error("port one not redirected");
    // a pointer written in one cycle steers the access of the next
    a_ptr_next_use: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_en_in && addr_in == `DMI_ADDR_PTR0 && op_in == DMI_OP_BYTE ##1 addr_in == `DMI_ADDR_IND0
        |-> eff_addr == $past(wdata_in))
        else $error("new pointer not used");
    // only the hardware strobe may move the protected byte
    a_prot_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !prot_we_in |=> $stable(protected_out))
        else $error("protected register changed");
    // alu results land in the working register
    a_alu_capture: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        alu_we_in |=> working_register_out == $past(alu_result_in))
        else $error("alu result missed");
    // the ram is never written below its first address
    a_gpr_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ram_bus.we |-> ram_bus.waddr >= `DMI_GPR_FIRST)
        else $error("ram write outside ram");
    // bit set on a special register
    a_bit_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_en_in && op_in == DMI_OP_BSET && eff_addr == `DMI_ADDR_WREG && !alu_we_in
        |=> working_register_out[$past(bit_sel_in)] == 1'b1)
        else $error("bit set failed");
    // bit clear on a special register
    a_bit_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_en_in && op_in == DMI_OP_BCLR && eff_addr == `DMI_ADDR_PTR1
        |=> pointer_one_out[$past(bit_sel_in)] == 1'b0)
        else $error("bit clear failed");
    // a bit operation leaves the other seven bits alone
    a_bit_others: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_en_in && op_in != DMI_OP_BYTE && eff_addr == `DMI_ADDR_PTR1
        |=> ((pointer_one_out ^ $past(pointer_one_out)) & ~(8'h01 << $past(bit_sel_in))) == 8'h00)
        else $error("bit operation disturbed other bits");
    // a ram bit operation writes its own byte on the next edge
    a_ram_bitop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_en_in && is_gpr && op_in != DMI_OP_BYTE |=> ram_bus.we && ram_bus.waddr == $past(eff_addr))
        else $error("ram bit operation not written back");
    // port zero stays inside bank zero
    a_port0_bank: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        addr_in == `DMI_ADDR_IND0 |-> eff_addr == (pointer_zero_out & `DMI_BANK0_MASK))
        else $error("port zero left its bank");
    // a write that resolves to a port touches no ram
    a_ind_no_ram: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_en_in && is_ind && !st_r.pend |-> !ram_bus.we)
        else $error("indirect self write reached ram");
    // special area writes never reach the ram array
    a_sfr_no_ram: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_en_in && !is_gpr && !st_r.pend |-> !ram_bus.we)
        else $error("special write reached ram");
    // working register reads back over the bus
    a_wreg_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rd_en_in && eff_addr == `DMI_ADDR_WREG |=> rdata_out == $past(working_register_out))
        else $error("working register read wrong");
    // working register takes a byte write when the alu is quiet
    a_wreg_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_en_in && op_in == DMI_OP_BYTE && eff_addr == `DMI_ADDR_WREG && !alu_we_in
        |=> working_register_out == $past(wdata_in))
        else $error("working register write lost");
    // pointer one reads back over the bus
    a_ptr1_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rd_en_in && eff_addr == `DMI_ADDR_PTR1 |=> rdata_out == $past(pointer_one_out))
        else $error("pointer one read wrong");
    // pointer one takes a byte write on the next edge
    a_ptr1_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_en_in && op_in == DMI_OP_BYTE && eff_addr == `DMI_ADDR_PTR1 |=> pointer_one_out == $past(wdata_in))
        else $error("pointer one write lost");
    // protected byte is readable though not writable
    a_prot_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rd_en_in && eff_addr == `DMI_ADDR_PROT |=> rdata_out == $past(protected_out))
        else $error("protected read wrong");
    // writes to the hole at 04h leave both pointers and the working register as they were
    a_unused_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_en_in && eff_addr == `DMI_ADDR_UNUSED && !alu_we_in
        |=> $stable(pointer_zero_out) && $stable(pointer_one_out) && $stable(working_register_out))
        else $error("unused write had an effect");
    // ram reads hand the array's registered byte to the bus
    a_gpr_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rd_en_in && is_gpr |=> rdata_out == ram_bus.rdata)
        else $error("ram read not routed");
    // reset clears the pointers and the working register
    a_reset_clear: assert property (@(posedge clk_in)
        !rst_n_in |=> pointer_zero_out == 8'h00 && pointer_one_out == 8'h00 && working_register_out == 8'h00)
        else $error("reset left a register set");
endmodule

// File: rtl/dmi_consts.svh
// address map and field constants for the data memory block
`ifndef DMI_CONSTS_SVH
`define DMI_CONSTS_SVH
`define DMI_ADDR_IND0 8'h00
`define DMI_ADDR_PTR0 8'h01
`define DMI_ADDR_IND1 8'h02
`define DMI_ADDR_PTR1 8'h03
`define DMI_ADDR_WREG 8'h05
`define DMI_ADDR_UNUSED 8'h04
`define DMI_ADDR_PROT 8'h08
`define DMI_SFR_LAST 8'h3f
`define DMI_GPR_FIRST 8'h40
`define DMI_ZERO_BYTE 8'h00
`define DMI_RST_BYTE 8'h00
`define DMI_BANK0_MASK 8'hff
`endif

// File: rtl/dmi_pkg.sv
// types shared by the data memory block
package dmi_pkg;
    typedef enum logic [1:0]
    {
        DMI_OP_BYTE,
        DMI_OP_BSET,
        DMI_OP_BCLR
    } dmi_op_t;
endpackage

// File: rtl/dmi_if.sv
// carrier between the data memory block and its ram
`timescale 1ns/100ps
interface dmi_ram_if;
    logic we;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic [7:0] raddr;
    logic [7:0] rdata;
    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// File: rtl/dmi_ram.sv
// general purpose ram array with registered read data
`timescale 1ns/100ps
module dmi_ram #(
    parameter int DEPTH = 256
) (
    input wire logic clk_in,
    dmi_ram_if.mem bus
);
    logic [7:0] mem_r [0:DEPTH-1];

    // no reset on the array: contents are volatile and undefined at power up
    always_ff @(posedge clk_in)
    begin
        if (bus.we)
        begin
            mem_r[bus.waddr] <= bus.wdata;
        end
        bus.rdata <= mem_r[bus.raddr];
    end
endmodule

// File: verif/dmi_core_model.sv
// core side model that hands alu results to the working register
`timescale 1ns/100ps
module dmi_core_model (
    input wire logic clk_in,
    input wire logic fire_in,
    input wire logic [7:0] val_in,
    output logic alu_we_out,
    output logic [7:0] alu_result_out
);
    // result is valid only with the strobe; otherwise it toggles so a stale value is never trusted
    always_ff @(posedge clk_in)
    begin
        alu_we_out <= fire_in;
        alu_result_out <= fire_in ? val_in : ~alu_result_out;
    end
endmodule

// File: verif/tb_data_memory_indirect_addressing.sv
// testbench for the data memory block with indirect access
`timescale 1ns/100ps
module tb_data_memory_indirect_addressing
    import dmi_pkg::*;
;
    logic clk_in = 0, rst_n = 0, rd_en = 0, wr_en = 0, fire = 0, prot_we = 0, alu_we, rvalid;
    logic [7:0] addr = 8'h00, wdata = 8'h00, val = 8'h00, prot_data = 8'h00, alu_res, rdata;
    logic [7:0] wreg, ptr0, ptr1, prot;
    dmi_op_t op = DMI_OP_BYTE;
    logic [2:0] bsel = 3'h0;
    int n_errors = 0, cmp_count = 0;
    always #50 clk_in = ~clk_in;
    dmi_core_model core (.clk_in(clk_in), .fire_in(fire), .val_in(val), .alu_we_out(alu_we),
        .alu_result_out(alu_res));
    dmi_top uut (.clk_in(clk_in), .rst_n_in(rst_n), .rd_en_in(rd_en), .wr_en_in(wr_en), .addr_in(addr),
        .op_in(op), .bit_sel_in(bsel), .wdata_in(wdata), .bank_in(1'b0), .alu_we_in(alu_we),
        .alu_result_in(alu_res), .prot_we_in(prot_we), .prot_data_in(prot_data), .rdata_out(rdata),
        .rvalid_out(rvalid), .working_register_out(wreg), .pointer_zero_out(ptr0),
        .pointer_one_out(ptr1), .protected_out(prot));
    task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        cmp_count++;
        if (s !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one request per call; consecutive calls land on consecutive edges
    task acc(input logic w, input logic [7:0] a, input logic [7:0] d, input dmi_op_t o = DMI_OP_BYTE,
        input logic [2:0] b = 3'h0);
        @(posedge clk_in);
        wr_en <= w;
        rd_en <= !w;
        addr <= a;
        wdata <= d;
        op <= o;
        bsel <= b;
    endtask
    // answer is looked at in the single cycle that it stands
    task rd(input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        @(posedge clk_in);
        rd_en <= 1'b0;
        @(negedge clk_in);
        chk("rvalid", 8'h01, {7'h00, rvalid});
        chk("rdata", e, rdata);
    endtask
    task idle;
        @(posedge clk_in);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        fire <= 1'b0;
        prot_we <= 1'b0;
        @(negedge clk_in);
    endtask
    task complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // watchdog sized well above the sixty or so cycles the tests need
    initial
    begin
        repeat (3000) @(posedge clk_in);
        n_errors++;
        complete_run;
    end
    initial
    begin
        repeat (10) @(posedge clk_in);
        rst_n <= 1'b1;
        idle;
        chk("ptr0", 8'h00, ptr0);
        chk("wreg", 8'h00, wreg);
        $display("test reset done");
        // both ends of the ram region, byte wide
        acc(1'b1, 8'h40, 8'ha5);
        acc(1'b1, 8'hff, 8'h5a);
        rd(8'h40, 8'ha5);
        rd(8'hff, 8'h5a);
        // ram bit operations, each followed by the free cycle the merge needs
        acc(1'b1, 8'h40, 8'h00, DMI_OP_BCLR, 3'h0);
        idle;
        acc(1'b1, 8'h40, 8'h00, DMI_OP_BSET, 3'h1);
        idle;
        rd(8'h40, 8'ha6);
        $display("test ram done");
        // pointer write followed at once by an indirect access
        acc(1'b1, 8'h45, 8'hc3);
        acc(1'b1, 8'h01, 8'h45);
        rd(8'h00, 8'hc3);
        acc(1'b1, 8'h00, 8'h99);
        rd(8'h45, 8'h99);
        acc(1'b1, 8'h03, 8'h80);
        acc(1'b1, 8'h02, 8'h3c);
        rd(8'h80, 8'h3c);
        rd(8'h03, 8'h80);
        acc(1'b1, 8'h01, 8'h00);
        acc(1'b1, 8'h00, 8'h77);
        rd(8'h00, 8'h00);
        $display("test indirect done");
        // unused and protected places drop writes, hardware sets the protected byte, bit operations merge into pointer one
        acc(1'b1, 8'h04, 8'hff);
        rd(8'h04, 8'h00);
        acc(1'b1, 8'h08, 8'hff);
        idle;
        chk("prot", 8'h00, prot);
        @(posedge clk_in);
        prot_we <= 1'b1;
        prot_data <= 8'h5a;
        idle;
        chk("prot", 8'h5a, prot);
        rd(8'h08, 8'h5a);
        acc(1'b1, 8'h03, 8'h00, DMI_OP_BSET, 3'h0);
        acc(1'b1, 8'h03, 8'h00, DMI_OP_BCLR, 3'h7);
        idle;
        chk("ptr1", 8'h01, ptr1);
        $display("test sfr done");
        // alu result beats a bus write to the working register
        @(posedge clk_in);
        fire <= 1'b1;
        val <= 8'h6e;
        acc(1'b1, 8'h05, 8'h11);
        idle;
        chk("wreg", 8'h6e, wreg);
        rd(8'h05, 8'h6e);
        acc(1'b1, 8'h05, 8'h2b);
        idle;
        chk("wreg", 8'h2b, wreg);
        acc(1'b1, 8'h05, 8'h00, DMI_OP_BSET, 3'h2);
        idle;
        chk("wreg", 8'h2f, wreg);
        $display("test working register done");
        complete_run;
    end
endmodule
